// ===== lms_pkg.sv
// constants and types for the led matrix scan timing block
package lms_pkg;

   // ****************************************************************
   // clock and times
   // ****************************************************************
   localparam int CLK_PERIOD_PS = 10000;
   localparam int CLK_MHZ = 100;
   localparam int T_PWM_FAST_NS = 8000;
   localparam int T_PWM_SLOW_NS = 16000;
   localparam int T_BLK_LONG_NS = 1000;
   localparam int T_BLK_SHORT_NS = 500;
   localparam int T_PHASE_PS = 125000;
   localparam int T_DLY_SLOW_PS = 62500;
   localparam int T_DLY_FAST_PS = 31250;
   localparam int T_RUN_US = 100;
   localparam int T_UVLO_US = 500;

   // least times round up to whole cycles
   localparam logic [10:0] PWM_FAST_CYC =
      11'((T_PWM_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [10:0] PWM_SLOW_CYC =
      11'((T_PWM_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [10:0] BLK_LONG_CYC =
      11'((T_BLK_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [10:0] BLK_SHORT_CYC =
      11'((T_BLK_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [10:0] PHASE_CYC =
      11'((T_PHASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [10:0] DLY_SLOW_CYC =
      11'((T_DLY_SLOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [10:0] DLY_FAST_CYC =
      11'((T_DLY_FAST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   // longest times round down
   localparam int RUN_CYC_DEF = T_RUN_US * CLK_MHZ;
   localparam int UVLO_CYC_DEF = T_UVLO_US * CLK_MHZ;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [31:0] ADDR_INIT = 32'h0000_0000;
   localparam logic [31:0] ADDR_RUN = 32'h0000_0004;
   localparam logic [31:0] ADDR_TIMING = 32'h0000_0008;
   localparam logic [31:0] ADDR_COMP = 32'h0000_000C;
   localparam logic [31:0] ADDR_GHOST = 32'h0000_0010;
   localparam logic [31:0] ADDR_PEAK = 32'h0000_0014;
   localparam logic [31:0] ADDR_STATUS = 32'h0000_0018;

   localparam int INIT_LINES_LSB = 0;
   localparam int INIT_MODE_LSB = 4;
   localparam int INIT_RATE_BIT = 8;
   localparam int RUN_BIT = 0;
   localparam int TIM_BLANK_BIT = 0;
   localparam int TIM_PHASE_BIT = 1;
   localparam int TIM_DLY_BIT = 2;
   localparam int COMP_LSB = 0;
   localparam int GHOST_LSB = 0;
   localparam int PEAK_LSB = 0;
   localparam int STAT_NORMAL_BIT = 0;
   localparam int STAT_LINE_LSB = 1;
   localparam int STAT_APPLIED_LSB = 4;

   localparam logic [2:0] LINES_RST = 3'h7;
   localparam logic [1:0] MODE_RST = 2'h1;
   localparam logic [2:0] PEAK_RST = 3'h3;
   localparam logic [2:0] LAST_LINE_MAX = 3'h6;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_BLANK, ST_ACTIVE} lms_state_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } lms_ahb_req_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } lms_ahb_rsp_t;

   typedef struct packed {
      logic [1:0] blue;
      logic [1:0] green;
      logic [1:0] red;
   } lms_comp_t;

   // settings whose update is deferred in frame modes
   typedef struct packed {
      logic [2:0] peak;
      logic [1:0] precharge;
      logic discharge;
   } lms_defer_t;

endpackage

// ===== lms_scan_timing.sv
// scan line sequencer, line timing, de-ghosting and peak current hold
`timescale 1ns/10ps
`default_nettype none

module lms_scan_timing
#(
   parameter int RUN_WAKE_CYC = lms_pkg::RUN_CYC_DEF,
   parameter int UVLO_WAKE_CYC = lms_pkg::UVLO_CYC_DEF
)
(
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   input wire lms_pkg::lms_ahb_req_t ahb_req_in,
   output var lms_pkg::lms_ahb_rsp_t ahb_rsp_out,
   input wire logic uvlo_active_in,
   input wire logic frame_sync_in,
   output var logic [6:0] scan_line_out,
   output var logic [5:0] sink_on_out,
   output var logic discharge_out,
   output var logic [1:0] precharge_out,
   output var lms_pkg::lms_comp_t comp_out,
   output var logic [2:0] peak_current_out,
   output var logic normal_out,
   output var logic frame_apply_out
);
   import lms_pkg::*;

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [2:0] line_count;
   logic [1:0] refresh_mode;
   logic pwm_rate;
   logic run;
   logic run_q;
   logic blank_sel;
   logic phase_en;
   logic dly_en;
   lms_comp_t comp_reg;
   lms_defer_t written;
   lms_defer_t staged;
   lms_defer_t applied;
   logic wr_pend;
   logic [31:0] wr_addr;
   logic [1:0] uvlo_sync;
   logic [2:0] fsync_sync;
   logic [31:0] wake_cnt;
   lms_state_t state;
   logic [10:0] cnt;
   logic [2:0] line;
   logic [10:0] lt_blk;
   logic [10:0] lt_pwm;
   logic [10:0] lt_ph;
   logic [10:0] lt_dly;
   logic [10:0] lt_act;
   logic [2:0] lt_last;
   logic [5:0] next_sink;
   logic deferred;
   logic run_rise;
   logic addr_ok;
   logic uvlo_s;
   logic fsync_rise;

   assign deferred = refresh_mode[1];
   assign run_rise = run && !run_q;
   assign addr_ok = ahb_req_in.hsel && ahb_req_in.htrans[1] &&
                    ahb_req_in.hready;
   assign uvlo_s = uvlo_sync[1];
   assign fsync_rise = fsync_sync[1] && !fsync_sync[2];

   // ****************************************************************
   // functions
   // ****************************************************************
   // value 0 in the line count field is taken as one line
   function automatic logic [2:0] last_line(input logic [2:0] cnt_f);
      last_line = (cnt_f == 3'h0) ? 3'h0 : cnt_f - 3'h1;
   endfunction

   function automatic logic [31:0] rd_mux(input logic [31:0] a);
      rd_mux = 32'h0000_0000;
      case (a)
         ADDR_INIT:
         begin
            rd_mux[INIT_LINES_LSB +: 3] = line_count;
            rd_mux[INIT_MODE_LSB +: 2] = refresh_mode;
            rd_mux[INIT_RATE_BIT] = pwm_rate;
         end
         ADDR_RUN: rd_mux[RUN_BIT] = run;
         ADDR_TIMING:
         begin
            rd_mux[TIM_BLANK_BIT] = blank_sel;
            rd_mux[TIM_PHASE_BIT] = phase_en;
            rd_mux[TIM_DLY_BIT] = dly_en;
         end
         ADDR_COMP: rd_mux[COMP_LSB +: 6] = comp_reg;
         ADDR_GHOST: rd_mux[GHOST_LSB +: 3] = written[2:0];
         ADDR_PEAK: rd_mux[PEAK_LSB +: 3] = written.peak;
         ADDR_STATUS:
         begin
            rd_mux[STAT_NORMAL_BIT] = normal_out;
            rd_mux[STAT_LINE_LSB +: 3] = line;
            rd_mux[STAT_APPLIED_LSB +: 6] = applied;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   endfunction

   // ****************************************************************
   // bus slave
   // ****************************************************************
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 32'h0000_0000;
         ahb_rsp_out <= '{hrdata: 32'h0000_0000, hreadyout: 1'b1,
                          hresp: 1'b0};
      end
      else
      begin
         wr_pend <= addr_ok && ahb_req_in.hwrite;
         wr_addr <= ahb_req_in.haddr;
         ahb_rsp_out.hreadyout <= 1'b1;
         ahb_rsp_out.hresp <= 1'b0;
         if (addr_ok && !ahb_req_in.hwrite)
            ahb_rsp_out.hrdata <= rd_mux(ahb_req_in.haddr);
      end
   end

   // software written settings
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         line_count <= LINES_RST;
         refresh_mode <= MODE_RST;
         pwm_rate <= 1'b0;
         run <= 1'b0;
         blank_sel <= 1'b0;
         phase_en <= 1'b0;
         dly_en <= 1'b0;
         comp_reg <= 6'h00;
         written <= '{peak: PEAK_RST, precharge: 2'h0, discharge: 1'b0};
      end
      else if (wr_pend)
      begin
         case (wr_addr)
            ADDR_INIT:
            begin
               line_count <= ahb_req_in.hwdata[INIT_LINES_LSB +: 3];
               refresh_mode <= ahb_req_in.hwdata[INIT_MODE_LSB +: 2];
               pwm_rate <= ahb_req_in.hwdata[INIT_RATE_BIT];
            end
            ADDR_RUN: run <= ahb_req_in.hwdata[RUN_BIT];
            ADDR_TIMING:
            begin
               blank_sel <= ahb_req_in.hwdata[TIM_BLANK_BIT];
               phase_en <= ahb_req_in.hwdata[TIM_PHASE_BIT];
               dly_en <= ahb_req_in.hwdata[TIM_DLY_BIT];
            end
            ADDR_COMP: comp_reg <= ahb_req_in.hwdata[COMP_LSB +: 6];
            ADDR_GHOST: written[2:0] <= ahb_req_in.hwdata[GHOST_LSB +: 3];
            ADDR_PEAK: written.peak <= ahb_req_in.hwdata[PEAK_LSB +: 3];
            default: line_count <= line_count;
         endcase
      end
   end

   // ****************************************************************
   // deferred update of peak code and de-ghost settings
   // ****************************************************************
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         run_q <= 1'b0;
         staged <= '{peak: PEAK_RST, precharge: 2'h0, discharge: 1'b0};
         applied <= '{peak: PEAK_RST, precharge: 2'h0, discharge: 1'b0};
      end
      else
      begin
         run_q <= run;
         if (!deferred)
            applied <= written;
         else
         begin
            if (!run)
               staged <= written;
            if (run_rise)
               applied <= staged;
         end
      end
   end

   // ****************************************************************
   // pin synchronisers and wake-up timer
   // ****************************************************************
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         uvlo_sync <= 2'h3;
         fsync_sync <= 3'h0;
      end
      else
      begin
         uvlo_sync <= {uvlo_sync[0], uvlo_active_in};
         fsync_sync <= {fsync_sync[1:0], frame_sync_in};
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         wake_cnt <= 32'h0000_0000;
         normal_out <= 1'b0;
      end
      else
      begin
         if (uvlo_s)
            wake_cnt <= 32'(UVLO_WAKE_CYC - 2);
         else if (run_rise && wake_cnt < 32'(RUN_WAKE_CYC - 2))
            wake_cnt <= 32'(RUN_WAKE_CYC - 2);
         else if (wake_cnt != 32'h0000_0000)
            wake_cnt <= wake_cnt - 32'h0000_0001;
         normal_out <= run && run_q && !uvlo_s && (wake_cnt == 32'h0000_0000);
      end
   end

   // ****************************************************************
   // line sequencer
   // ****************************************************************
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state <= ST_IDLE;
         cnt <= 11'h000;
         line <= 3'h0;
         lt_blk <= BLK_LONG_CYC;
         lt_pwm <= PWM_FAST_CYC;
         lt_ph <= 11'h000;
         lt_dly <= 11'h000;
         lt_act <= PWM_FAST_CYC;
         lt_last <= LAST_LINE_MAX;
      end
      else if (!normal_out)
      begin
         state <= ST_IDLE;
         cnt <= 11'h000;
         line <= 3'h0;
      end
      else
      begin
         cnt <= cnt + 11'h001;
         case (state)
            ST_IDLE, ST_BLANK:
            begin
               if (state == ST_IDLE || cnt == lt_blk - 11'h001)
                  cnt <= 11'h000;
               if (state == ST_IDLE)
               begin
                  // timing settings are taken at each line start; line count only at scan start and at wrap
                  state <= ST_BLANK;
                  line <= 3'h0;
                  lt_blk <= blank_sel ? BLK_SHORT_CYC : BLK_LONG_CYC;
                  lt_pwm <= pwm_rate ? PWM_SLOW_CYC : PWM_FAST_CYC;
                  lt_ph <= phase_en ? PHASE_CYC : 11'h000;
                  lt_dly <= dly_en ? (pwm_rate ? DLY_SLOW_CYC : DLY_FAST_CYC)
                                   : 11'h000;
                  lt_act <= (pwm_rate ? PWM_SLOW_CYC : PWM_FAST_CYC) +
                            (phase_en ? {PHASE_CYC[9:0], 1'b0} : 11'h000);
                  lt_last <= last_line(line_count);
               end
               else if (cnt == lt_blk - 11'h001)
                  state <= ST_ACTIVE;
            end
            ST_ACTIVE:
            begin
               if (cnt == lt_act - 11'h001)
               begin
                  // next line starts with its blank; back to 0 after last
                  state <= ST_BLANK;
                  cnt <= 11'h000;
               end
            end
            default: state <= ST_IDLE;
         endcase
         // wrap goes straight to line 0 so no idle cycle is added
         if (state == ST_ACTIVE && cnt == lt_act - 11'h001)
         begin
            state <= ST_BLANK;
            line <= (line == lt_last) ? 3'h0 : line + 3'h1;
            if (line == lt_last)
               lt_last <= last_line(line_count);
            lt_blk <= blank_sel ? BLK_SHORT_CYC : BLK_LONG_CYC;
            lt_pwm <= pwm_rate ? PWM_SLOW_CYC : PWM_FAST_CYC;
            lt_ph <= phase_en ? PHASE_CYC : 11'h000;
            lt_dly <= dly_en ? (pwm_rate ? DLY_SLOW_CYC : DLY_FAST_CYC)
                             : 11'h000;
            lt_act <= (pwm_rate ? PWM_SLOW_CYC : PWM_FAST_CYC) +
                      (phase_en ? {PHASE_CYC[9:0], 1'b0} : 11'h000);
         end
      end
   end

   // ****************************************************************
   // sink windows, phase shifted per colour pair
   // ****************************************************************
   for (genvar i = 0; i < 6; i++)
   begin : g_sink
      localparam int GRP = i % 3;
      logic [10:0] off;
      assign off = (GRP == 0) ? 11'h000 :
                   (GRP == 1) ? lt_ph : {lt_ph[9:0], 1'b0};
      assign next_sink[i] = (state == ST_ACTIVE) &&
                            (cnt >= off + lt_dly) &&
                            (cnt < off + lt_pwm);
   end

   // ****************************************************************
   // registered outputs
   // ****************************************************************
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         scan_line_out <= 7'h00;
         sink_on_out <= 6'h00;
         discharge_out <= 1'b0;
         precharge_out <= 2'h0;
         comp_out <= 6'h00;
         peak_current_out <= PEAK_RST;
         frame_apply_out <= 1'b0;
      end
      else
      begin
         scan_line_out <= (state == ST_ACTIVE) ? 7'(7'h01 << line)
                                              : 7'h00;
         sink_on_out <= next_sink;
         discharge_out <= (state == ST_BLANK) && applied.discharge;
         precharge_out <= (state == ST_BLANK) ? applied.precharge
                                             : 2'h0;
         comp_out <= comp_reg;
         peak_current_out <= applied.peak;
         frame_apply_out <= deferred ? fsync_rise : 1'b1;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   sequence s_line_end;
      state == ST_ACTIVE && cnt == lt_act - 11'h001;
   endsequence

   sequence s_blank_end;
      state == ST_BLANK && cnt == lt_blk - 11'h001;
   endsequence

   property p_one_line;
      $onehot0(scan_line_out);
   endproperty
   a_one_line: assert property (p_one_line)
      else $error("more than one scan line on");

   property p_sink_blank;
      scan_line_out == 7'h00 |-> sink_on_out == 6'h00;
   endproperty
   a_sink_blank: assert property (p_sink_blank)
      else $error("sink on while no line on");

   property p_line_step;
      s_line_end and (line != lt_last) and normal_out |=>
         state == ST_BLANK && line == $past(line) + 3'h1 &&
         cnt == 11'h000;
   endproperty
   a_line_step: assert property (p_line_step)
      else $error("line did not advance by one");

   property p_line_wrap;
      s_line_end and (line == lt_last) and normal_out |=>
         state == ST_BLANK && line == 3'h0 && cnt == 11'h000;
   endproperty
   a_line_wrap: assert property (p_line_wrap)
      else $error("scan did not wrap to line 0");

   property p_active_len;
      s_blank_end and normal_out |=> state == ST_ACTIVE &&
         cnt == 11'h000 && lt_act == lt_pwm + {lt_ph[9:0], 1'b0};
   endproperty
   a_active_len: assert property (p_active_len)
      else $error("active time not sink time plus twice phase");

   property p_pwm_time;
      state == ST_BLANK && cnt == 11'h000 |->
         lt_pwm == ($past(pwm_rate) ? 11'h640 : 11'h320);
   endproperty
   a_pwm_time: assert property (p_pwm_time)
      else $error("sink active time wrong for rate");

   property p_delay;
      lt_dly != 11'h000 && $rose(scan_line_out != 7'h00) |->
         sink_on_out == 6'h00;
   endproperty
   a_delay: assert property (p_delay)
      else $error("sinks on with line despite delay");

   property p_ghost_blank;
      discharge_out || precharge_out != 2'h0 |->
         scan_line_out == 7'h00;
   endproperty
   a_ghost_blank: assert property (p_ghost_blank)
      else $error("de-ghost active outside blank");

   property p_peak_now;
      !deferred && $changed(written.peak) |=> ##1
         peak_current_out == $past(written.peak, 2);
   endproperty
   a_peak_now: assert property (p_peak_now)
      else $error("peak code not applied at once");

   property p_peak_hold;
      deferred && run && run_q |=> $stable(applied);
   endproperty
   a_peak_hold: assert property (p_peak_hold)
      else $error("deferred setting changed while running");

   property p_wake;
      $fell(uvlo_s) |-> wake_cnt == 32'(UVLO_WAKE_CYC - 2);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake-up timer not loaded at lockout release");

   property p_frame;
      deferred && fsync_rise |=> frame_apply_out;
   endproperty
   a_frame: assert property (p_frame)
      else $error("frame sync not applied");

endmodule

`default_nettype wire

// ===== lms_matrix_model.sv
// far-side model of the led matrix: watches lines and sinks, drives sync
`timescale 1ns/10ps
`default_nettype none
module lms_matrix_model
#(
   parameter int SYNC_HIGH_CYC = 20000
)
(
   input wire logic ref_clk_in,
   input wire logic sync_req_in,
   input wire logic [6:0] scan_line_in,
   input wire logic [5:0] sink_on_in,
   output wire logic frame_sync_out,
   output var int period_out,
   output var int sink_dly_out,
   output var int fault_out
);
   // ****************************************************************
   // line period, sink delay, overlap faults, sync pulse
   // ****************************************************************
   int cnt = 0;
   int hold = 0;
   logic [6:0] scan_q = 7'h00;
   logic [5:0] sink_q = 6'h00;
   logic rise;
   assign rise = (|scan_line_in) && !(|scan_q);
   // sync held high for its full least width
   assign frame_sync_out = (hold != 0);
   always @(posedge ref_clk_in)
   begin
      scan_q <= scan_line_in;
      sink_q <= sink_on_in;
      cnt <= rise ? 1 : cnt + 1;
      if (rise)
         period_out <= cnt;
      if ((|sink_on_in) && !(|sink_q))
         sink_dly_out <= rise ? 0 : cnt;
      if ($countones(scan_line_in) > 1 ||
          (scan_line_in == 7'h00 && sink_on_in != 6'h00))
         fault_out <= fault_out + 1;
      if (sync_req_in)
         hold <= SYNC_HIGH_CYC;
      else if (hold > 0)
         hold <= hold - 1;
   end
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the led matrix scan timing block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import lms_pkg::*;
   localparam int RUN_W = 20;
   localparam int UV_W = 40;
   logic ref_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic uvlo_active_in = 1'b0;
   logic sync_req = 1'b0;
   logic frame_sync;
   lms_ahb_req_t req = '0;
   lms_ahb_req_t bus;
   lms_ahb_rsp_t rsp;
   logic [6:0] scan_line_out;
   logic [5:0] sink_on_out;
   logic discharge_out;
   logic [1:0] precharge_out;
   lms_comp_t comp_out;
   logic [2:0] peak_current_out;
   logic normal_out;
   logic frame_apply_out;
   int period;
   int sink_dly;
   int fault;
   int n_apply = 0;
   int a0;
   int n_mismatch = 0;
   int checks = 0;
   logic [31:0] rd;
   assign bus = {req[$bits(lms_ahb_req_t)-1:1], rsp.hreadyout};
   always #5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in)
      n_apply <= n_apply + int'(frame_apply_out === 1'b1);

   lms_scan_timing #(.RUN_WAKE_CYC(RUN_W), .UVLO_WAKE_CYC(UV_W))
      lms_scan_timing_inst (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
      .ahb_req_in(bus), .ahb_rsp_out(rsp), .uvlo_active_in(uvlo_active_in),
      .frame_sync_in(frame_sync), .scan_line_out(scan_line_out),
      .sink_on_out(sink_on_out), .discharge_out(discharge_out),
      .precharge_out(precharge_out), .comp_out(comp_out),
      .peak_current_out(peak_current_out), .normal_out(normal_out),
      .frame_apply_out(frame_apply_out));
   lms_matrix_model lms_matrix_model_inst (.ref_clk_in(ref_clk_in),
      .sync_req_in(sync_req), .scan_line_in(scan_line_out),
      .sink_on_in(sink_on_out), .frame_sync_out(frame_sync),
      .period_out(period), .sink_dly_out(sink_dly), .fault_out(fault));

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd);
      @(posedge ref_clk_in);
      req.hsel <= 1'b1;
      req.haddr <= a;
      req.htrans <= 2'b10;
      req.hwrite <= wr;
      req.hsize <= 3'b010;
      do @(posedge ref_clk_in); while (rsp.hreadyout !== 1'b1);
      req.hsel <= 1'b0;
      req.htrans <= 2'b00;
      req.hwdata <= wd;
      do @(posedge ref_clk_in); while (rsp.hreadyout !== 1'b1);
      rd = rsp.hrdata;
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic wnorm(input int lim);
      for (int i = 0; i < lim && normal_out !== 1'b1; i++)
         @(posedge ref_clk_in);
   endtask
   task automatic wline(input logic nz);
      for (int i = 0; i < 4000 && (|scan_line_out) !== nz; i++)
         @(posedge ref_clk_in);
   endtask
   task automatic nxtl;
      wline(1'b0);
      wline(1'b1);
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ****************************************************************
   // tests
   // ****************************************************************
   initial
   begin
      repeat (16) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      chk(peak_current_out, 32'(PEAK_RST));
      rchk(ADDR_PEAK, 32'h0000_0003);
      rchk(ADDR_INIT, 32'h0000_0017);
      rchk(32'h0000_0040, 32'h0000_0000);
      for (int c = 0; c < 3; c++)
      begin
         ahb(1'b1, ADDR_PEAK, 32'(c));
         repeat (3) @(posedge ref_clk_in);
         chk(peak_current_out, 32'(c));
      end
      chk(frame_apply_out, 32'h0000_0001);
      ahb(1'b1, ADDR_INIT, 32'h0000_0012);
      ahb(1'b1, ADDR_TIMING, 32'h0000_0000);
      ahb(1'b1, ADDR_GHOST, 32'h0000_0007);
      ahb(1'b1, ADDR_COMP, 32'h0000_0039);
      ahb(1'b1, ADDR_RUN, 32'h0000_0001);
      wnorm(RUN_W + 3);
      chk(normal_out, 32'h0000_0001);
      chk(comp_out, 32'h0000_0039);
      nxtl();
      chk(scan_line_out, 32'h0000_0001);
      wline(1'b0);
      repeat (2) @(posedge ref_clk_in);
      chk(discharge_out, 32'h0000_0001);
      chk(precharge_out, 32'h0000_0003);
      wline(1'b1);
      chk(scan_line_out, 32'h0000_0002);
      repeat (2) @(posedge ref_clk_in);
      chk(precharge_out, 32'h0000_0000);
      chk(period, 32'd900);
      chk(sink_dly, 32'd0);
      nxtl();
      chk(scan_line_out, 32'h0000_0001);
      uvlo_active_in <= 1'b1;
      repeat (5) @(posedge ref_clk_in);
      chk(normal_out, 32'h0000_0000);
      chk(period, 32'h0000_0384);
      uvlo_active_in <= 1'b0;
      wnorm(UV_W + 6);
      chk(normal_out, 32'h0000_0001);
      ahb(1'b1, ADDR_TIMING, 32'h0000_0007);
      ahb(1'b1, ADDR_INIT, 32'h0000_0112);
      nxtl();
      nxtl();
      nxtl();
      if (scan_line_out !== 7'h02)
         nxtl();
      repeat (2) @(posedge ref_clk_in);
      chk(period, 32'd1676);
      chk(sink_dly, 32'd7);
      ahb(1'b1, ADDR_INIT, 32'h0000_0122);
      ahb(1'b1, ADDR_PEAK, 32'h0000_0005);
      ahb(1'b1, ADDR_GHOST, 32'h0000_0000);
      repeat (4) @(posedge ref_clk_in);
      chk(peak_current_out, 32'h0000_0002);
      chk(frame_apply_out, 32'h0000_0000);
      nxtl();
      wline(1'b0);
      repeat (2) @(posedge ref_clk_in);
      chk(discharge_out, 32'h0000_0001);
      ahb(1'b1, ADDR_RUN, 32'h0000_0000);
      ahb(1'b1, ADDR_RUN, 32'h0000_0001);
      repeat (3) @(posedge ref_clk_in);
      chk(peak_current_out, 32'h0000_0005);
      rchk(ADDR_STATUS, 32'h0000_0280);
      wnorm(RUN_W + 3);
      nxtl();
      wline(1'b0);
      repeat (2) @(posedge ref_clk_in);
      chk(discharge_out, 32'h0000_0000);
      chk(precharge_out, 32'h0000_0000);
      a0 = n_apply;
      sync_req <= 1'b1;
      @(posedge ref_clk_in);
      sync_req <= 1'b0;
      repeat (10) @(posedge ref_clk_in);
      chk(32'(n_apply - a0), 32'h0000_0001);
      chk(fault, 32'h0000_0000);
      test_done;
   end
   initial
   begin
      #400000;
      n_mismatch++;
      test_done;
   end
endmodule
`default_nettype wire
